// file: wpc_map.vh
// Purpose: register map, field positions and timing constants of the wake power control block
// Assumes: 7-bit bank-2 register address, 8-bit data, a 32.768 kHz reference sampled on mclk
// Notes: included by the top and train design files of the block
// How it works
// - control registers cleared only by first power, lock byte also by hard reset
// - call input masked high until 1 s after return
// - time match in off state is remembered
// - pre-off events wake if no shutdown command
// - eight wake-up fields compared with clock fields
// - train mode samples falling edges per 62.5 ms slot
// - train event: three edge slots after quiet slot
// - outside train mode a single falling edge is a call event
// - soft-off bit write-only, one emits shutdown pulse
// - power-lost flag sets on supply loss, write-one clears
// - time match enable gates time wake request
// - call enable gates call wake request
// - status read clears event-detect bits
// - time match flag sets regardless of enable
// - call detect flag sets regardless of enable
// - call level bit shows current pin level
// - lock bits sticky, cleared only by first power or hard reset
// - upper block: upper port ignores writes, reads FFh
// - upper-low read block: bytes 00h-1Fh read FFh
// - upper-low write block: bytes 00h-1Fh writes dropped
// - write mask drops writes to listed ranges
// - top lock blocks lower 38h-3Fh in every bank
// - wake and shutdown requests are single high pulses
`ifndef WPC_MAP_VH
`define WPC_MAP_VH

`define WPC_OFS_PWR_CTRL_ONE 7'h40
`define WPC_OFS_PWR_CTRL_TWO 7'h41
`define WPC_OFS_EVENT_STATUS 7'h42
`define WPC_OFS_WAKE_DOW 7'h43
`define WPC_OFS_WAKE_DATE 7'h44
`define WPC_OFS_WAKE_MONTH 7'h45
`define WPC_OFS_WAKE_YEAR 7'h46
`define WPC_OFS_RAM_LOCK 7'h47
`define WPC_OFS_WAKE_CENTURY 7'h48

`define WPC_BIT_SOFT_OFF 5
`define WPC_BIT_POWER_LOST 7
`define WPC_BIT_TIME_EN 0
`define WPC_BIT_TRAIN_MODE 2
`define WPC_BIT_CALL_EN 3
`define WPC_BIT_TIME_FLAG 0
`define WPC_BIT_CALL_FLAG 1
`define WPC_BIT_CALL_LEVEL 7
`define WPC_BIT_UPPER_BLOCK 3
`define WPC_BIT_LOW_RD_BLOCK 4
`define WPC_BIT_LOW_WR_BLOCK 5
`define WPC_BIT_WRITE_MASK 6
`define WPC_BIT_TOP_LOCK 7
`define WPC_LOCK_BITS 8'hF8

`define WPC_RST_BYTE 8'h00
`define WPC_BLOCKED_READ 8'hFF
`define WPC_UPPER_LOW_LAST 7'h1F
`define WPC_GP_FIRST 7'h0E
`define WPC_GP_LAST 7'h3F
`define WPC_BANK0_HI_FIRST 7'h40
`define WPC_TOP_FIRST 7'h38
`define WPC_TOP_LAST 7'h3F
`define WPC_BANK_ZERO 2'h0

`define WPC_SLOW_HZ 32768
`define WPC_MASK_TIME_MS 1000
`define WPC_SLOT_TIME_US 62500
`define WPC_TRAIN_PATTERN 4'h7

`endif

// file: wpc_mem_model.sv
// Purpose: cmos ram behind the lock filter
// Assumes: combinational read of the addressed byte
// Notes: outside a read the bus shows a changing pattern, so stale data never passes
`timescale 1ns/100ps
module wpc_mem_model (
   // clock
   input wire mclk,
   // access from the filter
   input wire mem_upper_q,
   input wire [1:0] mem_bank_q,
   input wire [6:0] mem_addr_q,
   input wire [7:0] mem_wdata_q,
   input wire mem_we_q,
   input wire mem_re_q,
   // read data
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [0:1023];
   logic [7:0] noise_q = 8'h5A;
   wire [9:0] idx = {mem_upper_q, mem_bank_q, mem_addr_q};
   initial begin
      for (int i = 0; i < 1024; i++) mem[i] = 8'h00;
   end
   always @(posedge mclk) begin
      noise_q <= ~noise_q + 8'h01;
      if (mem_we_q) mem[idx] <= mem_wdata_q;
   end
   assign mem_rdata = mem_re_q ? mem[idx] : noise_q;
endmodule // wpc_mem_model

// file: wpc_sync.v
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs asynchronous to mclk
// Notes: first stage is read only by the second stage
`timescale 1ns/100ps
module wpc_sync #(
   parameter W = 4,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   // clock and reset
   input wire mclk,
   input wire rst,
   // pins in, synchronised out
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta_q;

   always @(posedge mclk) begin
      if (rst) begin
         meta_q <= INIT;
         q <= INIT;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule // wpc_sync

// file: wpc_top.v
// Purpose: wake/shutdown power control with event flags and cmos ram lock
// Assumes: por is a one-cycle-or-longer first-power pulse on mclk; pins are asynchronous
// Notes: system reset rst leaves control state alone; only por clears it, except the lock byte, which hard reset also clears
`timescale 1ns/100ps
`include "wpc_map.vh"
module wpc_top #(
   parameter integer MASK_TICKS = (`WPC_MASK_TIME_MS * `WPC_SLOW_HZ) / 1000
) (
   // clock and resets
   input wire mclk,
   input wire rst,
   input wire por,
   // pins
   input wire clk32_pin,
   input wire call_n_pin,
   input wire vcc_good_pin,
   input wire hard_reset_pin,
   // register port
   input wire [6:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata_q,
   // running clock fields
   input wire [7:0] cur_sec,
   input wire [7:0] cur_min,
   input wire [7:0] cur_hour,
   input wire [7:0] cur_dow,
   input wire [7:0] cur_date,
   input wire [7:0] cur_month,
   input wire [7:0] cur_year,
   input wire [7:0] cur_century,
   // alarm fields held in the clock registers
   input wire [7:0] alarm_sec,
   input wire [7:0] alarm_min,
   input wire [7:0] alarm_hour,
   // cmos ram access from the requester
   input wire acc_upper,
   input wire [1:0] acc_bank,
   input wire [6:0] acc_addr,
   input wire [7:0] acc_wdata,
   input wire acc_wr,
   input wire acc_rd,
   output reg [7:0] acc_rdata_q,
   // cmos ram access toward the memory
   output reg mem_upper_q,
   output reg [1:0] mem_bank_q,
   output reg [6:0] mem_addr_q,
   output reg [7:0] mem_wdata_q,
   output reg mem_we_q,
   output reg mem_re_q,
   input wire [7:0] mem_rdata,
   // power requests
   output reg wake_request_pulse_q,
   output reg shutdown_request_pulse_q
);
   localparam integer MASK_LAST_I = MASK_TICKS - 1;
   localparam [15:0] MASK_LAST = MASK_LAST_I[15:0];

   // synchronised pins
   wire [3:0] pins_s;
   wire clk32_s;
   wire call_s;
   wire vcc_s;
   wire hard_rst_s;

   // slow tick and supply edges
   reg clk32_prev_q;
   reg vcc_prev_q;
   wire tick;
   wire vcc_fall;
   wire vcc_rise;

   // control state, survives rst
   reg power_lost_flag_q;
   reg time_match_enable_q;
   reg call_train_mode_q;
   reg call_enable_q;
   reg time_match_flag_q;
   reg call_detect_flag_q;
   reg [7:0] wake_dow_q;
   reg [7:0] wake_date_q;
   reg [7:0] wake_month_q;
   reg [7:0] wake_year_q;
   reg [7:0] wake_century_q;
   reg [7:0] ram_lock_reg_q;
   reg off_q;
   reg delay_q;
   reg [15:0] mask_cnt_q;
   reg soc_seen_q;
   reg pend_q;

   // event detection
   reg call_prev_q;
   reg match_prev_q;
   wire call_masked;
   wire call_fall;
   wire train_ev;
   wire call_ev;
   wire all_match;
   wire time_ev;
   wire armed;
   wire wake_time;
   wire wake_call;
   wire pre_off_wake;

   // register decode
   wire wr_one;
   wire wr_two;
   wire rd_status;
   wire soc_write;
   reg [7:0] rd_mux;

   // ram lock decode
   reg rd_pend_q;
   reg rd_block_q;
   wire upper_low;
   wire in_gp;
   wire in_bank0_hi;
   wire in_top;
   wire wr_block;
   wire rd_block;

   wpc_sync #(
      .W(4),
      .INIT(4'hC)
   ) u_sync (
      .mclk(mclk),
      .rst(rst),
      .d({vcc_good_pin, call_n_pin, clk32_pin, hard_reset_pin}),
      .q(pins_s)
   );

   assign hard_rst_s = pins_s[0];
   assign clk32_s = pins_s[1];
   assign call_s = pins_s[2];
   assign vcc_s = pins_s[3];

   assign tick = clk32_s & ~clk32_prev_q;
   assign vcc_fall = vcc_prev_q & ~vcc_s;
   assign vcc_rise = vcc_s & ~vcc_prev_q;

   // the call pin is held high while off or during the return delay
   assign call_masked = (off_q | delay_q) ? 1'b1 : call_s;
   assign call_fall = call_prev_q & ~call_masked;

   wpc_train u_train (
      .mclk(mclk),
      .rst(rst | por),
      .tick(tick),
      .fall(call_fall),
      .train_ev_q(train_ev)
   );

   assign call_ev = call_train_mode_q ? train_ev : call_fall;

   assign all_match = (cur_sec == alarm_sec) & (cur_min == alarm_min) &
                      (cur_hour == alarm_hour) & (cur_dow == wake_dow_q) &
                      (cur_date == wake_date_q) & (cur_month == wake_month_q) &
                      (cur_year == wake_year_q) & (cur_century == wake_century_q);
   // a level match would fire every cycle of the matching second; take the edge
   assign time_ev = all_match & ~match_prev_q;

   assign armed = ~off_q & ~delay_q;
   assign wake_time = time_ev & time_match_enable_q;
   assign wake_call = call_ev & call_enable_q;
   assign pre_off_wake = ~soc_seen_q &
                         ((time_match_flag_q & time_match_enable_q) |
                          (call_detect_flag_q & call_enable_q) |
                          wake_time | wake_call);

   assign wr_one = reg_wr & (reg_addr == `WPC_OFS_PWR_CTRL_ONE);
   assign wr_two = reg_wr & (reg_addr == `WPC_OFS_PWR_CTRL_TWO);
   assign rd_status = reg_rd & (reg_addr == `WPC_OFS_EVENT_STATUS);
   assign soc_write = wr_one & reg_wdata[`WPC_BIT_SOFT_OFF];

   // pin, edge and pulse state follows rst
   always @(posedge mclk) begin
      if (rst | por) begin
         clk32_prev_q <= 1'b0;
         vcc_prev_q <= 1'b1;
         call_prev_q <= 1'b1;
         match_prev_q <= 1'b0;
         wake_request_pulse_q <= 1'b0;
         shutdown_request_pulse_q <= 1'b0;
      end else begin
         clk32_prev_q <= clk32_s;
         vcc_prev_q <= vcc_s;
         call_prev_q <= call_masked;
         match_prev_q <= all_match;
         wake_request_pulse_q <= armed & (wake_time | wake_call | pend_q);
         shutdown_request_pulse_q <= soc_write;
      end
   end

   // control state: only first power clears it
   always @(posedge mclk) begin
      if (por) begin
         power_lost_flag_q <= 1'b0;
         time_match_enable_q <= 1'b0;
         call_train_mode_q <= 1'b0;
         call_enable_q <= 1'b0;
         time_match_flag_q <= 1'b0;
         call_detect_flag_q <= 1'b0;
         wake_dow_q <= `WPC_RST_BYTE;
         wake_date_q <= `WPC_RST_BYTE;
         wake_month_q <= `WPC_RST_BYTE;
         wake_year_q <= `WPC_RST_BYTE;
         wake_century_q <= `WPC_RST_BYTE;
         off_q <= 1'b0;
         delay_q <= 1'b0;
         mask_cnt_q <= 16'h0000;
         soc_seen_q <= 1'b0;
         pend_q <= 1'b0;
      end else begin
         // set wins over the write-one clear
         power_lost_flag_q <= (power_lost_flag_q &
                               ~(wr_one & reg_wdata[`WPC_BIT_POWER_LOST])) | vcc_fall;
         if (wr_two) begin
            time_match_enable_q <= reg_wdata[`WPC_BIT_TIME_EN];
            call_train_mode_q <= reg_wdata[`WPC_BIT_TRAIN_MODE];
            call_enable_q <= reg_wdata[`WPC_BIT_CALL_EN];
         end
         time_match_flag_q <= (time_match_flag_q & ~rd_status) | time_ev;
         call_detect_flag_q <= (call_detect_flag_q & ~rd_status) | call_ev;
         if (reg_wr & (reg_addr == `WPC_OFS_WAKE_DOW)) wake_dow_q <= reg_wdata;
         if (reg_wr & (reg_addr == `WPC_OFS_WAKE_DATE)) wake_date_q <= reg_wdata;
         if (reg_wr & (reg_addr == `WPC_OFS_WAKE_MONTH)) wake_month_q <= reg_wdata;
         if (reg_wr & (reg_addr == `WPC_OFS_WAKE_YEAR)) wake_year_q <= reg_wdata;
         if (reg_wr & (reg_addr == `WPC_OFS_WAKE_CENTURY)) wake_century_q <= reg_wdata;
         // supply state and the return delay
         if (vcc_fall) begin
            off_q <= 1'b1;
            delay_q <= 1'b0;
         end else if (vcc_rise) begin
            off_q <= 1'b0;
            delay_q <= 1'b1;
            mask_cnt_q <= 16'h0000;
         end else if (delay_q & tick) begin
            if (mask_cnt_q == MASK_LAST) begin
               delay_q <= 1'b0;
            end else begin
               mask_cnt_q <= mask_cnt_q + 16'h0001;
            end
         end
         // a shutdown command counts only for the next off period
         if (soc_write) begin
            soc_seen_q <= 1'b1;
         end else if (vcc_rise) begin
            soc_seen_q <= 1'b0;
         end
         // wake requests held back while off or delayed
         if (armed & ~vcc_fall) begin
            pend_q <= 1'b0;
         end else if (vcc_fall) begin
            pend_q <= pend_q | pre_off_wake;
         end else begin
            pend_q <= pend_q | wake_time;
         end
      end
   end

   // lock bits only ever set by software
   always @(posedge mclk) begin
      if (por | hard_rst_s) begin
         ram_lock_reg_q <= `WPC_RST_BYTE;
      end else if (reg_wr & (reg_addr == `WPC_OFS_RAM_LOCK)) begin
         ram_lock_reg_q <= ram_lock_reg_q | (reg_wdata & `WPC_LOCK_BITS);
      end
   end

   always @* begin
      rd_mux = `WPC_RST_BYTE;
      case (reg_addr)
         `WPC_OFS_PWR_CTRL_ONE: begin
            rd_mux[`WPC_BIT_POWER_LOST] = power_lost_flag_q;
         end
         `WPC_OFS_PWR_CTRL_TWO: begin
            rd_mux[`WPC_BIT_TIME_EN] = time_match_enable_q;
            rd_mux[`WPC_BIT_TRAIN_MODE] = call_train_mode_q;
            rd_mux[`WPC_BIT_CALL_EN] = call_enable_q;
         end
         `WPC_OFS_EVENT_STATUS: begin
            rd_mux[`WPC_BIT_TIME_FLAG] = time_match_flag_q;
            rd_mux[`WPC_BIT_CALL_FLAG] = call_detect_flag_q;
            rd_mux[`WPC_BIT_CALL_LEVEL] = call_s;
         end
         `WPC_OFS_WAKE_DOW: rd_mux = wake_dow_q;
         `WPC_OFS_WAKE_DATE: rd_mux = wake_date_q;
         `WPC_OFS_WAKE_MONTH: rd_mux = wake_month_q;
         `WPC_OFS_WAKE_YEAR: rd_mux = wake_year_q;
         `WPC_OFS_RAM_LOCK: rd_mux = ram_lock_reg_q;
         `WPC_OFS_WAKE_CENTURY: rd_mux = wake_century_q;
         default: begin
            rd_mux = `WPC_RST_BYTE;
         end
      endcase
   end

   always @(posedge mclk) begin
      if (rst | por) begin
         reg_rdata_q <= `WPC_RST_BYTE;
      end else begin
         reg_rdata_q <= reg_rd ? rd_mux : `WPC_RST_BYTE;
      end
   end

   // cmos ram access filter
   assign upper_low = (acc_addr <= `WPC_UPPER_LOW_LAST);
   assign in_gp = (acc_addr >= `WPC_GP_FIRST) & (acc_addr <= `WPC_GP_LAST);
   assign in_bank0_hi = (acc_bank == `WPC_BANK_ZERO) & (acc_addr >= `WPC_BANK0_HI_FIRST);
   assign in_top = (acc_addr >= `WPC_TOP_FIRST) & (acc_addr <= `WPC_TOP_LAST);

   assign wr_block = acc_upper ?
      (ram_lock_reg_q[`WPC_BIT_UPPER_BLOCK] |
       ram_lock_reg_q[`WPC_BIT_WRITE_MASK] |
       (ram_lock_reg_q[`WPC_BIT_LOW_WR_BLOCK] & upper_low)) :
      ((ram_lock_reg_q[`WPC_BIT_WRITE_MASK] & (in_gp | in_bank0_hi)) |
       (ram_lock_reg_q[`WPC_BIT_TOP_LOCK] & in_top));
   assign rd_block = acc_upper ?
      (ram_lock_reg_q[`WPC_BIT_UPPER_BLOCK] |
       (ram_lock_reg_q[`WPC_BIT_LOW_RD_BLOCK] & upper_low)) :
      (ram_lock_reg_q[`WPC_BIT_TOP_LOCK] & in_top);

   // one stage toward the memory keeps every output on a flop
   always @(posedge mclk) begin
      if (rst | por) begin
         mem_upper_q <= 1'b0;
         mem_bank_q <= 2'h0;
         mem_addr_q <= 7'h00;
         mem_wdata_q <= `WPC_RST_BYTE;
         mem_we_q <= 1'b0;
         mem_re_q <= 1'b0;
         rd_pend_q <= 1'b0;
         rd_block_q <= 1'b0;
         acc_rdata_q <= `WPC_RST_BYTE;
      end else begin
         mem_upper_q <= acc_upper;
         mem_bank_q <= acc_bank;
         mem_addr_q <= acc_addr;
         mem_wdata_q <= acc_wdata;
         mem_we_q <= acc_wr & ~wr_block;
         mem_re_q <= acc_rd;
         rd_pend_q <= acc_rd;
         rd_block_q <= rd_block;
         if (rd_pend_q) begin
            acc_rdata_q <= rd_block_q ? `WPC_BLOCKED_READ : mem_rdata;
         end else begin
            acc_rdata_q <= `WPC_RST_BYTE;
         end
      end
   end
endmodule // wpc_top

// file: wpc_top_props.sv
// Purpose: port checks for wpc_top
// Assumes: rst and por both quiet every output pipe
// Notes: lock state is internal, so lock filtering is judged in the bench
`timescale 1ns/100ps
module wpc_top_props (
   // clock and resets
   input wire mclk,
   input wire rst,
   input wire por,
   // register port
   input wire [6:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [7:0] reg_rdata_q,
   // pin
   input wire call_n_pin,
   // ram path
   input wire [6:0] acc_addr,
   input wire acc_wr,
   input wire acc_rd,
   input wire [6:0] mem_addr_q,
   input wire mem_we_q,
   input wire mem_re_q,
   // requests
   input wire wake_request_pulse_q,
   input wire shutdown_request_pulse_q
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst || por);
   sequence s_soft_off;
      reg_wr && reg_addr == 7'h40 && reg_wdata[5];
   endsequence
   sequence s_re_echo;
      mem_re_q && mem_addr_q == $past(acc_addr);
   endsequence
   property p_soft_off;
      s_soft_off |=> shutdown_request_pulse_q;
   endproperty
   a_soft_off: assert property (p_soft_off) else $error("no shutdown pulse");
   property p_shut_cause;
      shutdown_request_pulse_q |-> $past(reg_wr && reg_addr == 7'h40 && reg_wdata[5]);
   endproperty
   a_shut_cause: assert property (p_shut_cause) else $error("stray shutdown pulse");
   property p_soc_read0;
      reg_rd && reg_addr == 7'h40 |=> !reg_rdata_q[5];
   endproperty
   a_soc_read0: assert property (p_soc_read0) else $error("soft-off bit read as one");
   property p_wake_pulse;
      wake_request_pulse_q |=> !wake_request_pulse_q;
   endproperty
   a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");
   property p_shut_pulse;
      shutdown_request_pulse_q |=> !shutdown_request_pulse_q;
   endproperty
   a_shut_pulse: assert property (p_shut_pulse) else $error("shutdown pulse too long");
   // pin must be steady past the synchroniser depth before the level is judged
   property p_call_lvl;
      $stable(call_n_pin)[*4] ##0 (reg_rd && reg_addr == 7'h42)
         |=> reg_rdata_q[7] == $past(call_n_pin);
   endproperty
   a_call_lvl: assert property (p_call_lvl) else $error("call level bit wrong");
   property p_mem_we;
      mem_we_q |-> $past(acc_wr) && mem_addr_q == $past(acc_addr);
   endproperty
   a_mem_we: assert property (p_mem_we) else $error("memory write without request");
   property p_acc_read;
      acc_rd |=> s_re_echo;
   endproperty
   a_acc_read: assert property (p_acc_read) else $error("memory read not issued");
endmodule // wpc_top_props
bind wpc_top wpc_top_props u_wpc_top_props (.mclk, .rst, .por, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata_q, .call_n_pin, .acc_addr, .acc_wr, .acc_rd, .mem_addr_q,
   .mem_we_q, .mem_re_q, .wake_request_pulse_q, .shutdown_request_pulse_q);

// file: wpc_top_tb_top.sv
// Purpose: self-checking bench for wpc_top
// Assumes: slow reference sped up to one tick per 4 mclk cycles
// Notes: expected values come from a small model of counts and ram contents
`timescale 1ns/100ps
module wpc_top_tb_top;
   localparam int SLOT = 8192;
   logic mclk = 0, rst = 1, por = 1, clk32_pin = 0, call_n_pin = 1, vcc_good_pin = 1;
   logic hard_reset_pin = 0, reg_wr = 0, reg_rd = 0, acc_upper = 0, acc_wr = 0, acc_rd = 0;
   logic [6:0] reg_addr = 0, acc_addr = 0, mem_addr_q;
   logic [7:0] reg_wdata = 0, acc_wdata = 0, reg_rdata_q, acc_rdata_q, mem_wdata_q, mem_rdata;
   logic [1:0] acc_bank = 0, mem_bank_q;
   logic mem_upper_q, mem_we_q, mem_re_q, wake_q, shut_q;
   logic [7:0] cur [8], wk [8], tm [int], lock = 0;
   logic [7:0] lk [6] = '{8'h00, 8'h20, 8'h10, 8'h80, 8'h40, 8'h08};
   logic [6:0] ra [5] = '{7'h40, 7'h41, 7'h42, 7'h47, 7'h50};
   logic [9:0] at [10] = '{10'h205, 10'h21F, 10'h220, 10'h038, 10'h037, 10'h1BF, 10'h090,
      10'h10D, 10'h045, 10'h160};
   int mismatches = 0, checked = 0, wakes = 0, shuts = 0, ew = 0;
   always #2 mclk = ~mclk;
   always #8 clk32_pin = ~clk32_pin;
   always @(posedge mclk) begin
      wakes <= wakes + wake_q;
      shuts <= shuts + shut_q;
   end
   wpc_top #(.MASK_TICKS(8)) u_wpc_top (.mclk, .rst, .por, .clk32_pin, .call_n_pin,
      .vcc_good_pin, .hard_reset_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
      .cur_sec(cur[0]), .cur_min(cur[1]), .cur_hour(cur[2]), .cur_dow(cur[3]),
      .cur_date(cur[4]), .cur_month(cur[5]), .cur_year(cur[6]), .cur_century(cur[7]),
      .alarm_sec(wk[0]), .alarm_min(wk[1]), .alarm_hour(wk[2]), .acc_upper, .acc_bank,
      .acc_addr, .acc_wdata, .acc_wr, .acc_rd, .acc_rdata_q, .mem_upper_q, .mem_bank_q,
      .mem_addr_q, .mem_wdata_q, .mem_we_q, .mem_re_q, .mem_rdata,
      .wake_request_pulse_q(wake_q), .shutdown_request_pulse_q(shut_q));
   wpc_mem_model u_wpc_mem_model (.mclk, .mem_upper_q, .mem_bank_q, .mem_addr_q,
      .mem_wdata_q, .mem_we_q, .mem_re_q, .mem_rdata);
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("mismatches %0d checked %0d", mismatches, checked);
      if (mismatches == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      @(posedge mclk);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge mclk);
      reg_wr <= 0;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] exp, input logic [7:0] m);
      @(posedge mclk);
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 0;
      #1 chk(reg_rdata_q & m, exp);
   endtask
   task automatic ring;
      @(posedge mclk);
      call_n_pin <= 0;
      repeat (100) @(posedge mclk);
      call_n_pin <= 1;
      repeat (20) @(posedge mclk);
   endtask
   task automatic tmatch(input int f);
      @(posedge mclk);
      cur[f] <= ~wk[f];
      repeat (4) @(posedge mclk);
      cur[f] <= wk[f];
      repeat (4) @(posedge mclk);
   endtask
   task automatic power_cycle;
      @(posedge mclk);
      vcc_good_pin <= 0;
      repeat (20) @(posedge mclk);
      ring;
      tmatch(0);
      chk(8'(wakes), 8'(ew));
      vcc_good_pin <= 1;
      repeat (12) @(posedge mclk);
      chk(8'(wakes), 8'(ew));
      repeat (80) @(posedge mclk);
   endtask
   // one write then one read of a ram byte, expectation from the lock model
   task automatic acc(input logic u, input logic [1:0] b, input logic [6:0] a);
      logic [7:0] v;
      logic wok, rok, top;
      v = $urandom;
      top = !u && a >= 7'h38 && a < 7'h40;
      wok = !(lock[6] && (u || a >= 7'h0E && (a < 7'h40 || b == 0)))
         && !(u && (lock[3] || lock[5] && a < 7'h20)) && !(lock[7] && top);
      rok = !(u && (lock[3] || lock[4] && a < 7'h20)) && !(lock[7] && top);
      if (wok) tm[{u, b, a}] = v;
      @(posedge mclk);
      acc_wr <= 1;
      acc_upper <= u;
      acc_bank <= b;
      acc_addr <= a;
      acc_wdata <= v;
      @(posedge mclk);
      acc_wr <= 0;
      acc_rd <= 1;
      @(posedge mclk);
      acc_rd <= 0;
      @(posedge mclk);
      #1 chk(acc_rdata_q, rok ? (tm.exists({u, b, a}) ? tm[{u, b, a}] : 8'h00) : 8'hFF);
   endtask
   // train test dominates: 2 quiet slots plus 16 pulses of about 2000 cycles
   initial begin
      repeat (70000) @(posedge mclk);
      mismatches++;
      tally_and_finish;
   end
   initial begin
      void'($urandom(32'h0842C1E8));
      foreach (wk[i]) begin
         wk[i] = $urandom;
         cur[i] = wk[i];
      end
      cur[0] = ~wk[0];
      repeat (16) @(posedge mclk);
      rst <= 0;
      por <= 0;
      repeat (4) @(posedge mclk);
      foreach (ra[i]) rd(ra[i], 8'h00, 8'h7F);
      wr(7'h41, 8'hFF);
      rd(7'h41, 8'h0D, 8'hFF);
      wr(7'h40, 8'h20);
      wr(7'h40, 8'h00);
      rd(7'h40, 8'h00, 8'hFF);
      chk(8'(shuts), 8'h01);
      for (int i = 3; i < 8; i++) wr(i == 7 ? 7'h48 : 7'(7'h40 + i), wk[i]);
      for (int en = 0; en < 2; en++) begin
         wr(7'h41, en ? 8'h09 : 8'h00);
         ring;
         ew += en;
         chk(8'(wakes), 8'(ew));
         rd(7'h42, 8'h02, 8'h02);
         rd(7'h42, 8'h00, 8'h03);
         for (int f = 0; f < 8; f++) begin
            tmatch(f);
            ew += en;
            chk(8'(wakes), 8'(ew));
         end
         rd(7'h42, 8'h01, 8'h03);
      end
      power_cycle;
      ew++;
      chk(8'(wakes), 8'(ew));
      rd(7'h42, 8'h00, 8'h02);
      rd(7'h40, 8'h80, 8'hFF);
      wr(7'h40, 8'h00);
      rd(7'h40, 8'h80, 8'hFF);
      wr(7'h40, 8'h80);
      rd(7'h40, 8'h00, 8'hFF);
      ring;
      ew++;
      power_cycle;
      ew++;
      chk(8'(wakes), 8'(ew));
      rd(7'h42, 8'h03, 8'h03);
      wr(7'h41, 8'h0C);
      repeat (2 * SLOT) @(posedge mclk);
      for (int i = 0; i < 16; i++) begin
         ring;
         repeat (1880) @(posedge mclk);
         if (i == 3) chk(8'(wakes), 8'(ew));
      end
      ew++;
      chk(8'(wakes), 8'(ew));
      rd(7'h42, 8'h02, 8'h02);
      foreach (lk[i]) begin
         wr(7'h47, lk[i]);
         lock |= lk[i];
         rd(7'h47, lock, 8'hFF);
         foreach (at[j]) acc(at[j][9], at[j][8:7], at[j][6:0]);
      end
      wr(7'h47, 8'h00);
      rst <= 1;
      repeat (3) @(posedge mclk);
      rst <= 0;
      repeat (4) @(posedge mclk);
      rd(7'h47, 8'hF8, 8'hFF);
      rd(7'h41, 8'h0C, 8'hFF);
      @(posedge mclk);
      hard_reset_pin <= 1;
      repeat (4) @(posedge mclk);
      hard_reset_pin <= 0;
      repeat (4) @(posedge mclk);
      rd(7'h47, 8'h00, 8'hFF);
      @(posedge mclk);
      call_n_pin <= 0;
      repeat (4) @(posedge mclk);
      rd(7'h42, 8'h00, 8'h80);
      tally_and_finish;
   end
endmodule // wpc_top_tb_top

// file: wpc_train.v
// Purpose: pulse-train detector on the masked call input
// Assumes: tick is a one-cycle pulse per 32.768 kHz period, fall a one-cycle edge pulse
// Notes: an edge in the closing cycle of a slot still counts for that slot
`timescale 1ns/100ps
`include "wpc_map.vh"
module wpc_train (
   // clock and reset
   input wire mclk,
   input wire rst,
   // slow tick and call edge
   input wire tick,
   input wire fall,
   // detection
   output reg train_ev_q
);
   localparam integer SLOT_TICKS = (`WPC_SLOT_TIME_US * `WPC_SLOW_HZ) / 1000000;
   localparam integer SLOT_LAST_I = SLOT_TICKS - 1;
   localparam [10:0] SLOT_LAST = SLOT_LAST_I[10:0];

   reg [10:0] slot_cnt_q;
   reg seen_q;
   reg [3:0] hist_q;
   wire slot_end;
   wire seen_now;
   wire [3:0] hist_d;

   assign slot_end = tick & (slot_cnt_q == SLOT_LAST);
   assign seen_now = seen_q | fall;
   assign hist_d = {hist_q[2:0], seen_now};

   always @(posedge mclk) begin
      if (rst) begin
         slot_cnt_q <= 11'h000;
         seen_q <= 1'b0;
         hist_q <= 4'h0;
         train_ev_q <= 1'b0;
      end else begin
         train_ev_q <= 1'b0;
         if (tick) begin
            slot_cnt_q <= slot_end ? 11'h000 : slot_cnt_q + 11'h001;
         end
         if (slot_end) begin
            hist_q <= hist_d;
            seen_q <= 1'b0;
            train_ev_q <= (hist_d == `WPC_TRAIN_PATTERN);
         end else if (fall) begin
            seen_q <= 1'b1;
         end
      end
   end
endmodule // wpc_train
